// *** core/wtu_defs.svh ***
`ifndef WTU_DEFS_SVH
`define WTU_DEFS_SVH

// register indices; byte address is four times the index
`define WTU_CTL_IDX 30'h00000093
`define WTU_RR_IDX 30'h00000094

// control register fields
`define WTU_EN_BIT 7
`define WTU_NMI_BIT 6
`define WTU_FLAG_BIT 5
`define WTU_PER_HI 1
`define WTU_PER_LO 0
`define WTU_CTL_RST 8'h00

// restart key bytes
`define WTU_KEY1 8'ha5
`define WTU_KEY2 8'h5a

// terminal counts, one less than the period in cycles
`define WTU_TC_SEL0 27'h7ffffff
`define WTU_TC_SEL1 27'h1ffffff
`define WTU_TC_SEL2 27'h03fffff
`define WTU_TC_SEL3 27'h003ffff

// width of the expiry reset pulse in cycles
`define WTU_RST_CYCLES 7'h40

`endif

// *** core/wtu_pkg.sv ***
`default_nettype none
package wtu_pkg;

  // software-visible control settings
  typedef struct packed {
    logic en;
    logic nmi_sel;
    logic [1:0] period;
  } wtu_ctrl_s;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic hit_ctl;
    logic hit_rr;
  } wtu_aph_s;

  // restart key sequencer, one-hot
  typedef enum logic [1:0] {
    WTU_SEQ_IDLE = 2'b01,
    WTU_SEQ_ARMED = 2'b10
  } wtu_seq_e;

endpackage : wtu_pkg
`default_nettype wire

// *** core/wtu_count.sv ***
`timescale 1ns/1ps
`default_nettype none
// up counter that advances only while run is high, with clear and terminal compare
module wtu_count (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [26:0] tc,
  output logic [26:0] cnt,
  output logic expire
);

  logic [26:0] cnt_ff; // elapsed cycles
  logic [26:0] nxt_cnt;

  // greater-or-equal so a shorter period chosen mid-count
  // still expires at once instead of wrapping round
  assign expire = run && (cnt_ff >= tc);
  assign cnt = cnt_ff;

  // next count
  always_comb begin
    if (clear || expire) begin
      nxt_cnt = 27'h0000000;
    end else if (run) begin
      nxt_cnt = cnt_ff + 27'h0000001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 27'h0000000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : wtu_count
`default_nettype wire

// *** core/wtu_pulse.sv ***
`timescale 1ns/1ps
`include "wtu_defs.svh"
`default_nettype none
// fixed-width pulse stretcher for the expiry reset
module wtu_pulse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trig,
  output logic pulse
);

  logic pulse_ff; // pulse output, registered
  logic [6:0] left_ff; // cycles still to go

  assign pulse = pulse_ff;

  // pulse is a flop, so it only moves on a rising edge or at the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= 1'b0;
      left_ff <= 7'h00;
    end else if (trig && !pulse_ff) begin
      pulse_ff <= 1'b1;
      left_ff <= `WTU_RST_CYCLES;
    end else if (pulse_ff) begin
      left_ff <= left_ff - 7'h01;
      // drop after the last counted cycle
      if (left_ff == 7'h01) begin
        pulse_ff <= 1'b0;
      end
    end
  end

endmodule : wtu_pulse
`default_nettype wire

// *** core/wtu_top.sv ***
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "wtu_defs.svh"
`default_nettype none
// watchdog timeout unit with ahb-lite register slave
module wtu_top
  import wtu_pkg::*;
#(
  parameter logic [26:0] TC_SEL0 = `WTU_TC_SEL0,
  parameter logic [26:0] TC_SEL1 = `WTU_TC_SEL1,
  parameter logic [26:0] TC_SEL2 = `WTU_TC_SEL2,
  parameter logic [26:0] TC_SEL3 = `WTU_TC_SEL3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic sys_rst_req,
  output logic nmi_req
);

  // ------------------------------------------------------------
  // bus side state
  // ------------------------------------------------------------
  wtu_aph_s aph_ff; // address phase held into data phase
  wtu_aph_s nxt_aph;
  logic hreadyout_ff; // zero wait states, always ready
  logic hresp_ff; // always okay
  logic [31:0] hrdata_ff; // read data for the data phase
  logic [31:0] nxt_hrdata;

  // ------------------------------------------------------------
  // watchdog state
  // ------------------------------------------------------------
  wtu_ctrl_s ctrl_ff; // enable, response select, period
  wtu_ctrl_s nxt_ctrl;
  logic flag_ff; // timeout indicator
  logic nxt_flag;
  logic nmi_ff; // nmi request level
  wtu_seq_e seq_ff; // restart key sequencer
  wtu_seq_e nxt_seq;

  // ------------------------------------------------------------
  // glue
  // ------------------------------------------------------------
  logic take; // address phase accepted this edge
  logic hit_ctl; // address matches control register
  logic hit_rr; // address matches restart register
  logic wr_ctl; // data-phase write to control
  logic wr_rr; // data-phase write to restart
  logic [7:0] wbyte; // low byte of write data
  logic restart; // second key seen after first
  logic [26:0] tc; // selected terminal count
  logic [26:0] cnt; // current elapsed count
  logic expire; // counter reached its terminal count
  logic to_rst; // expiry with reset response
  logic to_nmi; // expiry with interrupt response
  logic rst_busy; // reset pulse in progress
  logic run; // counter may advance

  assign take = hsel && htrans[1] && hready;
  assign hit_ctl = (haddr[31:2] == `WTU_CTL_IDX);
  assign hit_rr = (haddr[31:2] == `WTU_RR_IDX);
  assign wr_ctl = aph_ff.valid && aph_ff.write && aph_ff.hit_ctl;
  assign wr_rr = aph_ff.valid && aph_ff.write && aph_ff.hit_rr;
  assign wbyte = hwdata[7:0];

  // expiry splits by response select
  assign to_nmi = expire && ctrl_ff.nmi_sel;
  assign to_rst = expire && !ctrl_ff.nmi_sel;

  // hold the count still while the reset pulse runs
  assign run = ctrl_ff.en && !rst_busy;

  // outputs straight from flops
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign nmi_req = nmi_ff;
  assign sys_rst_req = rst_busy;

  // ------------------------------------------------------------
  // period decode: larger code, shorter timeout
  // ------------------------------------------------------------
  always_comb begin
    unique case (ctrl_ff.period)
      2'b00: tc = TC_SEL0;
      2'b01: tc = TC_SEL1;
      2'b10: tc = TC_SEL2;
      2'b11: tc = TC_SEL3;
    endcase
  end

  // ------------------------------------------------------------
  // address phase capture
  // ------------------------------------------------------------
  always_comb begin
    nxt_aph.valid = take;
    nxt_aph.write = hwrite;
    nxt_aph.hit_ctl = hit_ctl;
    nxt_aph.hit_rr = hit_rr;
  end

  // bus handshake flops; slave never stalls or errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      aph_ff <= nxt_aph;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control register next value
  // ------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (to_rst) begin
      // the chip is being reset, so come back up disabled
      nxt_ctrl = 4'(`WTU_CTL_RST);
    end else if (wr_ctl) begin
      // enable only ever sets from software
      nxt_ctrl.en = ctrl_ff.en | wbyte[`WTU_EN_BIT];
      nxt_ctrl.nmi_sel = wbyte[`WTU_NMI_BIT];
      nxt_ctrl.period = wbyte[`WTU_PER_HI:`WTU_PER_LO];
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= 4'(`WTU_CTL_RST);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ------------------------------------------------------------
  // timeout indicator: survives the pulse, only hresetn clears
  // ------------------------------------------------------------
  assign nxt_flag = flag_ff | expire;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ------------------------------------------------------------
  // restart key sequencer; any byte but the two keys disarms
  // ------------------------------------------------------------
  always_comb begin
    nxt_seq = seq_ff;
    restart = 1'b0;
    if (to_rst) begin
      nxt_seq = WTU_SEQ_IDLE;
    end else if (wr_rr) begin
      unique case (seq_ff)
        WTU_SEQ_IDLE: begin
          if (wbyte == `WTU_KEY1) begin
            nxt_seq = WTU_SEQ_ARMED;
          end
        end
        WTU_SEQ_ARMED: begin
          if (wbyte == `WTU_KEY2) begin
            restart = 1'b1;
            nxt_seq = WTU_SEQ_IDLE;
          end else if (wbyte != `WTU_KEY1) begin
            nxt_seq = WTU_SEQ_IDLE;
          end
        end
        default: begin
          nxt_seq = WTU_SEQ_IDLE; // illegal code recovers
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_ff <= WTU_SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ------------------------------------------------------------
  // nmi level: held until software restarts; a new expiry
  // in the same cycle as a restart wins
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_ff <= 1'b0;
    end else if (to_nmi) begin
      nmi_ff <= 1'b1;
    end else if (restart) begin
      nmi_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read data, taken from next values so that a write just
  // before a read is seen back-to-back
  // ------------------------------------------------------------
  always_comb begin
    nxt_hrdata = 32'h00000000;
    if (take && !hwrite && hit_ctl) begin
      nxt_hrdata[`WTU_EN_BIT] = nxt_ctrl.en;
      nxt_hrdata[`WTU_NMI_BIT] = nxt_ctrl.nmi_sel;
      nxt_hrdata[`WTU_FLAG_BIT] = nxt_flag;
      nxt_hrdata[`WTU_PER_HI:`WTU_PER_LO] = nxt_ctrl.period;
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ------------------------------------------------------------
  // counter and reset pulse
  // ------------------------------------------------------------
  wtu_count u_count (
    .clk(hclk),
    .rst_n(hresetn),
    .run(run),
    .clear(restart),
    .tc(tc),
    .cnt(cnt),
    .expire(expire)
  );

  wtu_pulse u_pulse (
    .clk(hclk),
    .rst_n(hresetn),
    .trig(to_rst),
    .pulse(rst_busy)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [7:0] rst_hi_cnt; // helper: length of the reset pulse

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_hi_cnt <= 8'h00;
    end else if (sys_rst_req) begin
      rst_hi_cnt <= rst_hi_cnt + 8'h01;
    end else begin
      rst_hi_cnt <= 8'h00;
    end
  end

  sequence s_arm;
    wr_rr && (wbyte == `WTU_KEY1) && !to_rst;
  endsequence

  sequence s_fire;
    wr_rr && (wbyte == `WTU_KEY2) && (seq_ff == WTU_SEQ_ARMED) &&
    !to_rst;
  endsequence

  sequence s_pulse_start;
    to_rst ##1 sys_rst_req;
  endsequence

  AST_IDLE_NO_COUNT: assert property (
    !ctrl_ff.en |=> (cnt == $past(cnt)) || (cnt == 27'h0000000))
    else $error("counter moved while disabled");

  AST_ENABLE_SET: assert property (
    wr_ctl && wbyte[`WTU_EN_BIT] && !to_rst |=> ctrl_ff.en)
    else $error("enable write did not take");

  AST_ENABLE_STICKY: assert property (
    ctrl_ff.en && !to_rst |=> ctrl_ff.en)
    else $error("enable cleared without reset");

  AST_EXPIRE_AT_TC: assert property (
    expire |-> cnt >= tc)
    else $error("expiry before terminal count");

  AST_FLAG_ON_EXPIRE: assert property (
    expire |=> flag_ff)
    else $error("timeout flag not set");

  AST_RESET_RESPONSE: assert property (
    s_pulse_start |-> !ctrl_ff.en && (!nmi_req || $past(nmi_req)))
    else $error("reset response missing");

  AST_PULSE_WIDTH: assert property (
    $fell(sys_rst_req) |-> rst_hi_cnt == 8'h40)
    else $error("reset pulse not 64 cycles");

  AST_NMI_RESPONSE: assert property (
    to_nmi |=> nmi_req && !sys_rst_req)
    else $error("nmi response wrong");

  AST_FLAG_READ: assert property (
    take && !hwrite && hit_ctl |=> hrdata[`WTU_FLAG_BIT] == flag_ff)
    else $error("flag not visible on read");

  AST_KEY_ARM: assert property (
    s_arm |=> seq_ff == WTU_SEQ_ARMED)
    else $error("first key did not arm");

  AST_KEY_RESTART: assert property (
    s_fire ##1 !expire |-> cnt == 27'h0000000)
    else $error("restart did not clear count");

endmodule : wtu_top
`default_nettype wire

// *** testbench/wtu_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// cpu-side sink: watches the expiry reset request and the nmi level
module wtu_cpu_model (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic nmi,
  output int pulse_w,
  output int n_pulse,
  output int n_nmi,
  output int edge_err
);
  int run_w; // cycles counted in the pulse now running
  realtime t_pos; // time of the latest rising clock edge

  // counters start clean; the model has no reset of its own
  initial begin
    pulse_w = 0;
    n_pulse = 0;
    n_nmi = 0;
    edge_err = 0;
    run_w = 0;
    t_pos = 0;
  end

  // width in whole cycles: each edge that sees the request high adds one
  always @(posedge clk) begin
    t_pos = $realtime;
    if (rst_req === 1'b1) begin
      run_w++;
    end else if (run_w != 0) begin
      pulse_w = run_w;
      n_pulse++;
      run_w = 0;
    end
  end

  // a change away from a rising edge would reach the cpu as a glitch
  always @(rst_req) begin
    if ($realtime != t_pos) edge_err++;
  end

  // the core latches every new nmi assertion once
  always @(posedge nmi) begin
    n_nmi++;
  end
endmodule : wtu_cpu_model
`default_nettype wire

// *** testbench/watchdog_timeout_unit_tb.sv ***
`timescale 1ns/1ps
`include "wtu_defs.svh"
`default_nettype none
// self-checking bench: ahb-lite master, cpu sink model, watchdog
module watchdog_timeout_unit_tb
  import wtu_pkg::*;
;
  // short periods keep the run small; index is the period code
  localparam int PER [4] = '{256, 128, 64, 32};
  localparam logic [31:0] A_CTL = {`WTU_CTL_IDX, 2'b00};
  localparam logic [31:0] A_RR = {`WTU_RR_IDX, 2'b00};
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, sys_rst_req, nmi_req;
  logic [31:0] hrdata;
  int n_errors, cmp_count;
  int pulse_w, n_pulse, n_nmi, edge_err;

  wtu_top #(
    .TC_SEL0(27'(PER[0] - 1)), .TC_SEL1(27'(PER[1] - 1)),
    .TC_SEL2(27'(PER[2] - 1)), .TC_SEL3(27'(PER[3] - 1))
  ) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sys_rst_req(sys_rst_req), .nmi_req(nmi_req)
  );

  wtu_cpu_model u_cpu (
    .clk(hclk), .rst_req(sys_rst_req), .nmi(nmi_req), .pulse_w(pulse_w),
    .n_pulse(n_pulse), .n_nmi(n_nmi), .edge_err(edge_err)
  );

  // 50 mhz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // verdict and end of run, shared with the hang guard
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // hang guard: the whole sequence needs under two thousand cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    stop_test();
  end

  // one comparison, four-state exact
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // next edge with hready high; bounded so a stuck slave cannot hang us
  task automatic edge_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n == 50) n_errors++;
  endtask : edge_ready

  // single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask : xfer

  // byte write; only the low byte matters to either register
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {24'h0, d}, x);
  endtask : wr

  // read and compare a register
  task automatic rd_chk(input string w, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(w, x, e);
    check("hresp okay", {31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // reset held for 12 cycles, released just after an edge
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // cycles until the nmi level is seen high
  task automatic time_nmi(output int t);
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (nmi_req !== 1'b1 && t < 2000);
    if (t >= 2000) n_errors++;
  endtask : time_nmi

  // main sequence
  initial begin
    int t [4];
    int w0, n;
    logic [7:0] b;
    n_errors = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    w0 = $urandom(54883);
    do_reset();
    // disabled and quiet out of reset
    rd_chk("ctl after reset", A_CTL, 32'h0);
    repeat (300) @(posedge hclk);
    check("idle events", 32'(n_pulse + n_nmi), 32'h0);
    // stray write to a hole must not land in the control register
    wr(A_CTL - 32'h4, 8'hff);
    rd_chk("unmapped", A_CTL - 32'h4, 32'h0);
    rd_chk("restart reads", A_RR, 32'h0);
    rd_chk("ctl untouched", A_CTL, 32'h0);
    // nmi response, longest code first
    wr(A_CTL, 8'hc0);
    time_nmi(w0);
    check("first nmi", 32'(w0 >= 256 && w0 <= 260), 32'h1);
    for (int p = 0; p < 4; p++) begin
      // random attempt to clear enable, junk in flag and reserved bits
      b = 8'($urandom) & 8'hbc;
      wr(A_CTL, b | 8'h40 | 8'(p));
      rd_chk("ctl fields", A_CTL, 32'he0 | 32'(p));
      wr(A_RR, 8'ha5);
      wr(A_RR, 8'h5a);
      time_nmi(t[p]);
      // a foreign byte between the keys disarms the restart
      do b = 8'($urandom); while (b == 8'ha5 || b == 8'h5a);
      wr(A_RR, 8'ha5);
      wr(A_RR, b);
      wr(A_RR, 8'h5a);
      @(posedge hclk);
      check("nmi kept", {31'h0, nmi_req}, 32'h1);
    end
    // offsets cancel in the differences, so the decode shows exactly
    for (int p = 0; p < 3; p++) begin
      check("period step", 32'(t[p] - t[3]), 32'(PER[p] - PER[3]));
    end
    check("short period", 32'(t[3] >= 32 && t[3] <= 34), 32'h1);
    check("nmi count", 32'(n_nmi), 32'h5);
    check("no reset in nmi mode", 32'(n_pulse), 32'h0);
    // second reset in mid-run clears everything, flag included
    do_reset();
    rd_chk("ctl after rerun", A_CTL, 32'h0);
    check("nmi dropped", {31'h0, nmi_req}, 32'h0);
    // default reset response with the shortest period
    wr(A_CTL, 8'h83);
    n = 0;
    while (n_pulse == 0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 300) n_errors++;
    check("pulse width", 32'(pulse_w), 32'd64);
    check("edge aligned", 32'(edge_err), 32'h0);
    rd_chk("ctl after expiry", A_CTL, 32'h20);
    repeat (200) @(posedge hclk);
    check("single pulse", 32'(n_pulse), 32'h1);
    check("no nmi in reset mode", 32'(n_nmi), 32'h5);
    stop_test();
  end
endmodule : watchdog_timeout_unit_tb
`default_nettype wire
